/* hdl/dmcr_pkg.sv */
// Constants for the DAC mode control register bank
package dmcr_pkg;
  localparam logic [6:0] IDX_ATT_LEFT = 7'h10;
  localparam logic [6:0] IDX_ATT_RIGHT = 7'h11;
  localparam logic [6:0] IDX_MUTE_CTRL = 7'h12;
  localparam logic [6:0] IDX_DIS_DEEMPH = 7'h13;
  localparam logic [6:0] IDX_FORMAT = 7'h14;
  localparam logic [6:0] IDX_PHASE = 7'h16;
  localparam int WORD_BITS = 16;
  localparam logic [7:0] ATT_RESET = 8'hff;
  localparam logic [7:0] ATT_MUTE_MAX = 8'h80;
  localparam logic [7:0] ATT_MUTE_CODE = 8'h00;
  localparam logic [2:0] FMT_RESET = 3'h5;
  localparam logic [1:0] DMF_RESET = 2'h0;
  localparam int BIT_MUTE_L = 0;
  localparam int BIT_MUTE_R = 1;
  localparam int BIT_OVER = 6;
  localparam int BIT_SOFT_REINIT = 7;
  localparam int BIT_DIS_L = 0;
  localparam int BIT_DIS_R = 1;
  localparam int BIT_DEEMPH = 4;
  localparam int BIT_DMF_LO = 5;
  localparam int BIT_FLT = 5;
  localparam int BIT_PHASE = 0;
  localparam int RAMP_SAMPLES = 8;
  localparam int FS_DEFAULT_DIV = 512;
endpackage : dmcr_pkg

/* hdl/dmcr_ramp_if.sv */
// Carrier between the register bank and one channel's attenuation ramp
`timescale 1ns/1ps
`default_nettype none
interface dmcr_ramp_if;
  logic [7:0] target;
  logic mute;
  logic step;
  logic [7:0] level;
  modport ctrl (output target, output mute, output step, input level);
  modport ramp (input target, input mute, input step, output level);
endinterface : dmcr_ramp_if
`default_nettype wire

/* hdl/dmcr_ramp.sv */
// One channel's stepped attenuation ramp with soft mute
`timescale 1ns/1ps
`default_nettype none
module dmcr_ramp
  import dmcr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic soft_rst_i,
  dmcr_ramp_if.ramp rif
);
  logic [7:0] goal;
  logic [7:0] level;

  // Codes at or below the mute threshold collapse to the silent code
  always_comb begin
    if (rif.mute || rif.target <= ATT_MUTE_MAX) begin
      goal = ATT_MUTE_CODE;
    end else begin
      goal = rif.target;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      level <= ATT_RESET;
    end else if (soft_rst_i) begin
      level <= ATT_RESET;
    end else if (rif.step && level != goal) begin
      if (goal == ATT_MUTE_CODE && level <= ATT_MUTE_MAX) begin
        level <= ATT_MUTE_CODE;
      end else if (level == ATT_MUTE_CODE && goal > ATT_MUTE_MAX) begin
        level <= ATT_MUTE_MAX + 8'h01;
      end else if (level < goal) begin
        level <= level + 8'h01;
      end else begin
        level <= level - 8'h01;
      end
    end
  end

  assign rif.level = level;

  AST_RAMP_HOLD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!rif.step && !soft_rst_i) |=> $stable(level))
    else $error("attenuation moved without a ramp tick");
endmodule : dmcr_ramp
`default_nettype wire

/* hdl/dmcr_top.sv */
// Three-wire write-only mode control register bank of a stereo DAC
`timescale 1ns/1ps
`default_nettype none
module dmcr_top
  import dmcr_pkg::*;
#(
  parameter int FS_DIV = FS_DEFAULT_DIV
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic control_shift_clock_i,
  input wire logic control_latch_i,
  input wire logic control_serial_data_i,
  input wire logic sample_strobe_i,
  output logic [7:0] left_channel_attenuation_code_o,
  output logic [7:0] right_channel_attenuation_code_o,
  output logic [7:0] left_level_o,
  output logic [7:0] right_level_o,
  output logic left_channel_soft_mute_o,
  output logic right_channel_soft_mute_o,
  output logic oversample_double_o,
  output logic left_channel_disable_o,
  output logic right_channel_disable_o,
  output logic deemphasis_enable_o,
  output logic [1:0] deemphasis_rate_select_o,
  output logic [2:0] audio_format_select_o,
  output logic rolloff_select_o,
  output logic output_phase_invert_o,
  output logic [7:0] reg18_raw_o,
  output logic [7:0] reg22_raw_o
);
  // Link domain: shift register runs on the control shift clock
  logic [WORD_BITS-1:0] shift_word;
  logic [4:0] bit_count;
  logic [WORD_BITS-1:0] held_word;
  logic held_toggle;

  always_ff @(posedge control_shift_clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_word <= '0;
    end else if (!control_latch_i) begin
      shift_word <= {shift_word[WORD_BITS-2:0], control_serial_data_i};
    end
  end

  always_ff @(posedge control_shift_clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_count <= 5'h00;
    end else if (!control_latch_i) begin
      // First edge of a new frame restarts the count, or short frames would pass
      if (frame_mark != latch_seen) begin
        bit_count <= 5'h01;
      end else if (bit_count != 5'h1f) begin
        bit_count <= bit_count + 5'h01;
      end
    end
  end

  // Shift clock stops between frames, so the falling latch toggles a frame marker and the first shift edge restarts the counter
  logic latch_seen;
  always_ff @(negedge control_latch_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      latch_seen <= 1'b0;
    end else begin
      latch_seen <= ~latch_seen;
    end
  end
  logic [WORD_BITS-1:0] frame_word;
  logic [4:0] frame_bits;
  logic frame_mark;
  always_ff @(posedge control_shift_clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_mark <= 1'b0;
    end else if (!control_latch_i) begin
      frame_mark <= latch_seen;
    end
  end
  assign frame_bits = (frame_mark != latch_seen) ? 5'h00 : bit_count;
  assign frame_word = shift_word;

  // Rising latch captures a complete word and signals by toggle
  always_ff @(posedge control_latch_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      held_word <= '0;
      held_toggle <= 1'b0;
    end else if (frame_bits >= 5'(WORD_BITS) && frame_mark == latch_seen) begin
      held_word <= frame_word;
      held_toggle <= ~held_toggle;
    end
  end

  // Toggle crossing into the system clock domain
  logic [2:0] tog_sync;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tog_sync <= 3'h0;
    end else begin
      tog_sync <= {tog_sync[1:0], held_toggle};
    end
  end
  logic word_ready;
  assign word_ready = tog_sync[2] ^ tog_sync[1];

  // Held word is stable for many cycles after the toggle, so sampling it is safe
  logic [6:0] wr_index;
  logic [7:0] wr_data;
  logic wr_lead;
  assign wr_lead = held_word[15];
  assign wr_index = held_word[14:8];
  assign wr_data = held_word[7:0];

  logic [7:0] att_left;
  logic [7:0] att_right;
  logic [7:0] mute_ctrl;
  logic [7:0] dis_deemph;
  logic [7:0] fmt_ctrl;
  logic [7:0] phase_ctrl;
  logic soft_rst;
  logic wr_ok;
  assign wr_ok = word_ready && !wr_lead;

  assign soft_rst = wr_ok && wr_index == IDX_MUTE_CTRL && wr_data[BIT_SOFT_REINIT];

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      att_left <= ATT_RESET;
      att_right <= ATT_RESET;
      mute_ctrl <= 8'h00;
      dis_deemph <= {1'b0, DMF_RESET, 5'h00};
      fmt_ctrl <= {5'h00, FMT_RESET};
      phase_ctrl <= 8'h00;
    end else if (soft_rst) begin
      att_left <= ATT_RESET;
      att_right <= ATT_RESET;
      mute_ctrl <= 8'h00;
      dis_deemph <= {1'b0, DMF_RESET, 5'h00};
      fmt_ctrl <= {5'h00, FMT_RESET};
      phase_ctrl <= 8'h00;
    end else if (wr_ok) begin
      if (wr_index == IDX_ATT_LEFT) begin
        att_left <= wr_data;
      end else if (wr_index == IDX_ATT_RIGHT) begin
        att_right <= wr_data;
      end else if (wr_index == IDX_MUTE_CTRL) begin
        mute_ctrl <= wr_data;
      end else if (wr_index == IDX_DIS_DEEMPH) begin
        dis_deemph <= wr_data;
      end else if (wr_index == IDX_FORMAT) begin
        fmt_ctrl <= wr_data;
      end else if (wr_index == IDX_PHASE) begin
        phase_ctrl <= wr_data;
      end
    end
  end

  // Tick every eight sample periods, from the rising edge of the sample strobe
  logic [2:0] strobe_sync;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strobe_sync <= 3'h0;
    end else begin
      strobe_sync <= {strobe_sync[1:0], sample_strobe_i};
    end
  end
  logic sample_tick;
  assign sample_tick = strobe_sync[1] & ~strobe_sync[2];

  logic [2:0] sample_count;
  logic ramp_step;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sample_count <= 3'h0;
    end else if (sample_tick) begin
      sample_count <= sample_count + 3'h1;
    end
  end
  assign ramp_step = sample_tick && sample_count == 3'(RAMP_SAMPLES - 1);

  dmcr_ramp_if left_if ();
  dmcr_ramp_if right_if ();

  assign left_if.target = att_left;
  assign left_if.mute = mute_ctrl[BIT_MUTE_L];
  assign left_if.step = ramp_step;
  assign right_if.target = att_right;
  assign right_if.mute = mute_ctrl[BIT_MUTE_R];
  assign right_if.step = ramp_step;

  dmcr_ramp u_left (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .soft_rst_i(soft_rst),
    .rif(left_if.ramp)
  );

  dmcr_ramp u_right (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .soft_rst_i(soft_rst),
    .rif(right_if.ramp)
  );

  assign left_channel_attenuation_code_o = att_left;
  assign right_channel_attenuation_code_o = att_right;
  assign left_level_o = left_if.level;
  assign right_level_o = right_if.level;
  assign left_channel_soft_mute_o = mute_ctrl[BIT_MUTE_L];
  assign right_channel_soft_mute_o = mute_ctrl[BIT_MUTE_R];
  assign oversample_double_o = mute_ctrl[BIT_OVER];
  assign left_channel_disable_o = dis_deemph[BIT_DIS_L];
  assign right_channel_disable_o = dis_deemph[BIT_DIS_R];
  assign deemphasis_enable_o = dis_deemph[BIT_DEEMPH];
  assign deemphasis_rate_select_o = dis_deemph[BIT_DMF_LO+1:BIT_DMF_LO];
  assign audio_format_select_o = fmt_ctrl[2:0];
  assign rolloff_select_o = fmt_ctrl[BIT_FLT];
  assign output_phase_invert_o = phase_ctrl[BIT_PHASE];
  assign reg18_raw_o = mute_ctrl;
  assign reg22_raw_o = phase_ctrl;

  AST_SOFT_RESET: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    soft_rst |=> (att_left == ATT_RESET && fmt_ctrl[2:0] == FMT_RESET && mute_ctrl == 8'h00))
    else $error("soft reset did not restore defaults");
  AST_LEFT_WRITE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_ok && wr_index == IDX_ATT_LEFT) |=> att_left == $past(wr_data))
    else $error("left attenuation write lost");
  AST_UNDEF_IGNORED: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_ok && wr_index == 7'h15) |=> ($stable(att_left) && $stable(fmt_ctrl) && $stable(phase_ctrl)))
    else $error("undefined index changed a register");
  AST_MUTE_DOWN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (ramp_step && mute_ctrl[BIT_MUTE_L] && left_if.level > ATT_MUTE_MAX + 8'h01 && !soft_rst)
      |=> left_if.level == $past(left_if.level) - 8'h01)
    else $error("muted left channel did not step down");
  AST_DISABLE_MAP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_ok && wr_index == IDX_DIS_DEEMPH && !soft_rst) |=> right_channel_disable_o == $past(wr_data[1]))
    else $error("right disable not taken from bit 1");
  AST_STEP_RATE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ramp_step |=> !ramp_step)
    else $error("ramp ticked twice in a row");
  AST_OVER_MAP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_ok && wr_index == IDX_MUTE_CTRL && !wr_data[BIT_SOFT_REINIT]) |=> oversample_double_o == $past(wr_data[6]))
    else $error("oversample bit mismatch");
  AST_PHASE_MAP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_ok && wr_index == IDX_PHASE) |=> output_phase_invert_o == $past(wr_data[0]))
    else $error("phase bit mismatch");
endmodule : dmcr_top
`default_nettype wire

/* testbench/dmcr_host.sv */
// Host controller model driving the three-wire control port
`timescale 1ns/1ps
`default_nettype none
module dmcr_host (
  output logic control_latch_o,
  output logic control_shift_clock_o,
  output logic control_serial_data_o
);
  // Shift clock stands still low between frames
  initial begin
    control_latch_o = 1'b1;
    control_shift_clock_o = 1'b0;
    control_serial_data_o = 1'b1;
  end

  task automatic send(input logic [15:0] word, input int nbits);
    #37 control_latch_o = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      control_serial_data_o = word[i];
      #62.5 control_shift_clock_o = 1'b1;
      #62.5 control_shift_clock_o = 1'b0;
    end
    #30 control_latch_o = 1'b1;
    // Released line must not keep showing the last bit
    control_serial_data_o = ~control_serial_data_o;
  endtask
endmodule // dmcr_host
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the DAC mode control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strobe = 1'b0;
  logic ml, mc, md;
  logic [7:0] latt, ratt, llev, rlev, r18, r22;
  logic mute_l, mute_r, over, dis_l, dis_r, dem, rolloff_select, ph;
  logic [1:0] dmf;
  logic [2:0] fmt;
  int fail_count = 0;
  int compares = 0;
  int n;
  int sdiv = 0;
  // oversample raised as for fast rates
  // Word sent, output picked, value expected
  localparam logic [31:0] ROWS [22] = '{
    32'h1081_0081, 32'h1100_0100, 32'h1203_0203, 32'h1240_0301, 32'h1240_0a40,
    32'h1303_0403, 32'h1310_0501, 32'h1320_0601, 32'h1340_0602, 32'h1360_0603,
    32'h1300_0600, 32'h1420_0801, 32'h1601_0901, 32'h1601_0b01, 32'h1400_0700,
    32'h1401_0701, 32'h1402_0702, 32'h1403_0703, 32'h1404_0704, 32'h1405_0705,
    32'h1406_0706, 32'h1407_0707};

  always #20 clk = ~clk;
  // One sample period every four clocks keeps ramp runs short
  always @(negedge clk) begin
    sdiv <= sdiv + 1;
    if (sdiv[0]) strobe <= ~strobe;
  end

  dmcr_host dmcr_host_i (.control_latch_o(ml), .control_shift_clock_o(mc),
    .control_serial_data_o(md));
  dmcr_top dmcr_top_i (.ref_clk_i(clk), .sys_rst_i(rst), .control_shift_clock_i(mc),
    .control_latch_i(ml), .control_serial_data_i(md), .sample_strobe_i(strobe),
    .left_channel_attenuation_code_o(latt), .right_channel_attenuation_code_o(ratt),
    .left_level_o(llev), .right_level_o(rlev), .left_channel_soft_mute_o(mute_l),
    .right_channel_soft_mute_o(mute_r), .oversample_double_o(over),
    .left_channel_disable_o(dis_l), .right_channel_disable_o(dis_r),
    .deemphasis_enable_o(dem), .deemphasis_rate_select_o(dmf),
    .audio_format_select_o(fmt), .rolloff_select_o(rolloff_select), .output_phase_invert_o(ph),
    .reg18_raw_o(r18), .reg22_raw_o(r22));

  function automatic logic [7:0] seen(input logic [7:0] s);
    case (s)
      8'h00: seen = latt;
      8'h01: seen = ratt;
      8'h02: seen = {6'h00, mute_r, mute_l};
      8'h03: seen = {7'h00, over};
      8'h04: seen = {6'h00, dis_r, dis_l};
      8'h05: seen = {7'h00, dem};
      8'h06: seen = {6'h00, dmf};
      8'h07: seen = {5'h00, fmt};
      8'h08: seen = {7'h00, rolloff_select};
      8'h09: seen = {7'h00, ph};
      8'h0a: seen = r18;
      default: seen = r22;
    endcase
  endfunction

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] w, input int nb = 16);
    dmcr_host_i.send(w, nb);
    repeat (8) @(negedge clk);
  endtask

  task automatic until_lvl(input logic right, input logic [7:0] v, input int lim);
    n = 0;
    while (((right ? rlev : llev) !== v) && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic defaults();
    check("att", {latt, ratt}, 16'hffff);
    check("lvl", {llev, rlev}, 16'hffff);
    check("raw", {r18, r22}, 16'h0000);
    check("ctl", {3'h0, mute_r, mute_l, over, dis_r, dis_l, dem, dmf, fmt, rolloff_select, ph},
      16'h0014);
  endtask

  initial begin
    #2_000_000;
    fail_count++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) rst <= 1'b0;
    @(negedge clk);
    defaults();
    wr(16'h10fd);
    until_lvl(1'b0, 8'hfe, 64);
    check("first step", {8'h00, llev}, 16'h00fe);
    until_lvl(1'b0, 8'hfd, 64);
    check("step gap", n[15:0], 16'h0020);
    repeat (64) @(negedge clk);
    check("settled", {llev, rlev}, 16'hfdff);
    wr(16'h1201);
    until_lvl(1'b0, 8'h00, 5000);
    check("mute time", 16'(n inside {[3940:4010]}), 16'h0001);
    check("right kept", {8'h00, rlev}, 16'h00ff);
    wr(16'h1200);
    until_lvl(1'b0, 8'hfd, 5000);
    check("unmute time", 16'(n inside {[3940:4010]}), 16'h0001);
    repeat (64) @(negedge clk);
    check("restored", {llev, latt}, 16'hfdfd);
    wr(16'h1180);
    until_lvl(1'b1, 8'h00, 5000);
    check("code 128", {llev, rlev}, 16'hfd00);
    foreach (ROWS[k]) begin
      wr(ROWS[k][31:16]);
      check("row", {8'h00, seen(ROWS[k][15:8])}, {8'h00, ROWS[k][7:0]});
    end
    // Undefined index, set top bit, short frame
    wr(16'h15ff);
    wr(16'h90ff);
    wr(16'h10ff, 15);
    check("refused", {latt, r22}, 16'h8101);
    wr(16'h1280);
    defaults();
    wr(16'h1601);
    rst <= 1'b1;
    repeat (3) @(negedge clk);
    defaults();
    rst <= 1'b0;
    @(negedge clk);
    defaults();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
